// ===== design/acc_ctrl.sv
`timescale 1ns/100ps
module acc_ctrl
#(
  parameter int PERIOD_LO_CYC = acc_pkg::PERIOD_LO_CYC,
  parameter int PERIOD_HI_CYC = acc_pkg::PERIOD_HI_CYC
)
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       acr_start,
  input  wire logic       acr_enable,
  input  wire logic       acr_rate_hi,
  input  wire logic [3:0] flash_nibble,
  output logic            autozero_q,
  output logic            sample_q,
  output logic            ladder_lsb_q,
  output logic            busy_q,
  output logic            done_q,
  output logic [7:0]      result_q
);

  // ********************************************************************
  // State
  // ********************************************************************
  acc_pkg::acc_state_t          state_q;
  acc_pkg::acc_state_t          state_d;
  logic [acc_pkg::CNT_W-1:0]    cnt_q;
  logic [acc_pkg::CNT_W-1:0]    cnt_d;
  logic                         running_q;
  logic                         running_d;
  logic                         rate_hi_q;
  logic                         rate_hi_d;
  logic [3:0]                   upper_q;
  logic [3:0]                   upper_d;
  logic [7:0]                   result_d;
  logic                         done_d;
  logic                         autozero_d;
  logic                         sample_d;
  logic                         ladder_lsb_d;
  logic                         busy_d;
  logic                         tick;
  logic                         start_ok;
  logic [acc_pkg::PERIOD_W-1:0] period;
  logic                         msb_end;
  logic                         lsb_end;

  // Disabled converter takes no start
  assign start_ok = acr_start && acr_enable; // RULE13

  // Rate comes from the copy latched at start, not the live bit
  assign period = rate_hi_q ? acc_pkg::PERIOD_W'(PERIOD_HI_CYC)
                            : acc_pkg::PERIOD_W'(PERIOD_LO_CYC); // RULE6

  // ********************************************************************
  // Sample pacing
  // ********************************************************************
  acc_timer u_sample_pacing_timer
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (running_q),
    .restart (start_ok),
    .period  (period),
    .tick_q  (tick)
  ); // RULE8

  // ********************************************************************
  // Conversion sequencer
  // ********************************************************************
  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q + acc_pkg::CNT_W'(1);
    running_d = running_q;
    rate_hi_d = rate_hi_q;
    if (!acr_enable)
    begin
      // Low power: drop state, count and run flag, keep last result and latched rate
      state_d   = acc_pkg::ACC_IDLE; // RULE5
      running_d = 1'b0; // RULE13
      cnt_d     = '0;
    end
    else if (start_ok)
    begin
      // Abort any conversion and restart from auto-zero
      state_d   = acc_pkg::ACC_ZERO; // RULE1 RULE2 RULE3
      cnt_d     = '0;
      running_d = 1'b1;
      rate_hi_d = acr_rate_hi; // RULE4 RULE7
    end
    else
    begin
      unique case (state_q)
        acc_pkg::ACC_IDLE:
        begin
          cnt_d = '0;
          // A tick during a conversion is dropped, not queued
          if (running_q && tick)
          begin
            state_d = acc_pkg::ACC_ZERO; // RULE8
          end
        end
        acc_pkg::ACC_ZERO:
        begin
          if (cnt_q == acc_pkg::AZ_LAST)
          begin
            state_d = acc_pkg::ACC_MSB; // RULE10
            cnt_d   = '0;
          end
        end
        acc_pkg::ACC_MSB:
        begin
          if (msb_end)
          begin
            state_d = acc_pkg::ACC_LSB;
            cnt_d   = '0;
          end
        end
        acc_pkg::ACC_LSB:
        begin
          if (lsb_end)
          begin
            state_d = acc_pkg::ACC_IDLE;
            cnt_d   = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q   <= acc_pkg::ACC_IDLE;
      cnt_q     <= '0;
      running_q <= 1'b0;
      rate_hi_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      running_q <= running_d;
      rate_hi_q <= rate_hi_d;
    end
  end

  // ********************************************************************
  // Result capture
  // ********************************************************************
  // A step cut short by disable or a new start never lands
  assign msb_end = acr_enable && !start_ok &&
                   (state_q == acc_pkg::ACC_MSB) &&
                   (cnt_q == acc_pkg::HALF_LAST);
  assign lsb_end = acr_enable && !start_ok &&
                   (state_q == acc_pkg::ACC_LSB) &&
                   (cnt_q == acc_pkg::HALF_LAST);

  always_comb
  begin
    upper_d  = upper_q;
    result_d = result_q;
    done_d   = 1'b0;
    if (msb_end)
    begin
      // Upper nibble waits here until the lower one completes the word
      upper_d = flash_nibble; // RULE11
    end
    if (lsb_end)
    begin
      // Two half steps of 900 ns stay inside 2 us
      result_d = {upper_q, flash_nibble}; // RULE9 RULE11 RULE12
      done_d   = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      upper_q  <= acc_pkg::NIBBLE_RST;
      result_q <= acc_pkg::RESULT_RST;
      done_q   <= 1'b0;
    end
    else
    begin
      upper_q  <= upper_d;
      result_q <= result_d;
      done_q   <= done_d;
    end
  end

  // ********************************************************************
  // Phase outputs
  // ********************************************************************
  // Decoded from the next state so each output is a plain flip-flop
  always_comb
  begin
    autozero_d   = (state_d == acc_pkg::ACC_ZERO); // RULE10
    sample_d     = (state_d == acc_pkg::ACC_MSB) ||
                   (state_d == acc_pkg::ACC_LSB);
    ladder_lsb_d = (state_d == acc_pkg::ACC_LSB); // RULE11
    busy_d       = (state_d != acc_pkg::ACC_IDLE);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      autozero_q   <= 1'b0;
      sample_q     <= 1'b0;
      ladder_lsb_q <= 1'b0;
      busy_q       <= 1'b0;
    end
    else
    begin
      autozero_q   <= autozero_d;
      sample_q     <= sample_d;
      ladder_lsb_q <= ladder_lsb_d;
      busy_q       <= busy_d;
    end
  end

endmodule // acc_ctrl

// ===== design/acc_pkg.sv
// Behaviour
// RULE1: Writing the start bit of the analog_control_register launches a conversion.
// RULE2: A start command is taken at any time, idle or busy.
// RULE3: Start during a running conversion aborts it and launches a fresh one.
// RULE4: Setting changes take effect only at the next start command.
// RULE5: An analog_control_register enable bit powers the converter down or up.
// RULE6: Two sampling rates, 10 kHz and 16 kHz, are selectable.
// RULE7: Software picks the rate through the analog_control_register rate bit.
// RULE8: The sample_pacing_timer paces every sampling period of the converter.
// RULE9: Conversion phase finishes within 2 microseconds of its start.
// RULE10: Each sampling period auto-zeroes the converter before converting.
// RULE11: Result is resolved as upper four bits first, then lower four bits.
// RULE12: Last completed 8-bit result is held until the next one completes.
// RULE13: While disabled, start commands are ignored and nothing is sampled.
package acc_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_HZ       = 50_000_000;
  localparam int CLK_MHZ      = CLK_HZ / 1_000_000;
  // Nominal crystal_clock for which the two rates are specified
  localparam int CRYSTAL_HZ   = 20_480_000;
  localparam int RATE_LO_HZ   = 10_000;
  localparam int RATE_HI_HZ   = 16_000;
  localparam int PERIOD_LO_CYC = CLK_HZ / RATE_LO_HZ;
  localparam int PERIOD_HI_CYC = CLK_HZ / RATE_HI_HZ;
  localparam int PERIOD_W     = 13;

  // Auto-zero is a least time: round up
  localparam int AZ_NS        = 500;
  localparam int AZ_CYC       = (AZ_NS * CLK_MHZ + 999) / 1000;
  // Conversion is a longest time, split over two half-flash steps
  localparam int CONV_MAX_NS  = 2000;
  localparam int HALF_NS      = 900;
  localparam int HALF_CYC     = (HALF_NS * CLK_MHZ) / 1000;
  localparam int CNT_W        = 7;
  localparam logic [CNT_W-1:0] AZ_LAST   = CNT_W'(AZ_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [3:0] NIBBLE_RST = 4'h0;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_ZERO,
    ACC_MSB,
    ACC_LSB
  } acc_state_t;

endpackage

// ===== design/acc_timer.sv
`timescale 1ns/100ps
module acc_timer
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         run,
  input  wire logic                         restart,
  input  wire logic [acc_pkg::PERIOD_W-1:0] period,
  output logic                              tick_q
);

  logic [acc_pkg::PERIOD_W-1:0] cnt_q;
  logic [acc_pkg::PERIOD_W-1:0] cnt_d;
  logic                         tick_d;

  // ********************************************************************
  // Period counter
  // ********************************************************************
  always_comb
  begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (restart)
    begin
      // Start edge is cycle 0 of the first period, so it counts
      cnt_d = acc_pkg::PERIOD_W'(1);
    end
    else if (!run)
    begin
      cnt_d = '0;
    end
    else if (cnt_q == period - acc_pkg::PERIOD_W'(1))
    begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + acc_pkg::PERIOD_W'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule // acc_timer

// ===== sim/acc_ctrl_assertions.sv
`timescale 1ns/100ps
module acc_checker
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       acr_start,
  input wire logic       acr_enable,
  input wire logic       acr_rate_hi,
  input wire logic [3:0] flash_nibble,
  input wire logic       autozero_q,
  input wire logic       sample_q,
  input wire logic       ladder_lsb_q,
  input wire logic       busy_q,
  input wire logic       done_q,
  input wire logic [7:0] result_q
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  start_taken_a: assert property (acr_start && acr_enable |=> busy_q && autozero_q)
    else $error("start not taken");
  zero_first_a: assert property ($rose(sample_q) |-> $past(autozero_q))
    else $error("sampling without auto-zero");
  conv_bound_a: assert property ($fell(autozero_q) && sample_q |-> ##[1:100] !sample_q)
    else $error("conversion too long");
  upper_first_a: assert property ($rose(ladder_lsb_q) |-> sample_q && $past(sample_q))
    else $error("lower step out of order");
  lower_nib_a: assert property (done_q |-> result_q[3:0] == $past(flash_nibble))
    else $error("lower nibble wrong");
  result_hold_a: assert property ($changed(result_q) |-> done_q)
    else $error("result moved without done");
  done_pulse_a: assert property (done_q |=> !done_q)
    else $error("done longer than a cycle");
  off_idle_a: assert property (!acr_enable |=> !busy_q && !sample_q)
    else $error("active while disabled");
  cover property (done_q);
  cover property (acr_start && busy_q);
  cover property (!acr_enable && busy_q);
endmodule // acc_checker

// ===== sim/acc_ctrl_bench.sv
`timescale 1ns/100ps
module acc_ctrl_bench;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       acr_start = 1'b0;
  logic       acr_enable = 1'b1;
  logic       acr_rate_hi = 1'b0;
  logic [7:0] level = 8'ha5;
  logic [3:0] flash_nibble;
  logic       autozero_q, sample_q, ladder_lsb_q, busy_q, done_q;
  logic [7:0] result_q;
  int         num_errors = 0;
  int         n_checks = 0;
  int         n, m;
  logic       act;
  always #10 clk_sys = ~clk_sys;
  acc_ctrl #(.PERIOD_LO_CYC(200), .PERIOD_HI_CYC(150)) DUT (.clk_sys(clk_sys),
    .rst(rst), .acr_start(acr_start), .acr_enable(acr_enable),
    .acr_rate_hi(acr_rate_hi), .flash_nibble(flash_nibble),
    .autozero_q(autozero_q), .sample_q(sample_q), .ladder_lsb_q(ladder_lsb_q),
    .busy_q(busy_q), .done_q(done_q), .result_q(result_q));
  acc_flash_model model (.clk_sys(clk_sys), .sample_q(sample_q),
    .ladder_lsb_q(ladder_lsb_q), .level(level), .flash_nibble(flash_nibble));
  task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait, cycles counted from the next falling edge
  task automatic wait_hi(ref logic sig, output int k);
    k = 0;
    do @(negedge clk_sys) k++; while (sig !== 1'b1 && k < 400);
    if (k >= 400)
    begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic go;
    @(negedge clk_sys) acr_start = 1'b1;
    @(negedge clk_sys) acr_start = 1'b0;
  endtask
  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    go();
    wait_hi(done_q, n);
    chk("latency", n, 115);
    chk("result", result_q, 8'ha5);
    $display("basic test ended");
    level = 8'hc3;
    go();
    repeat (80) @(negedge clk_sys);
    chk("held", result_q, 8'ha5);
    go();
    wait_hi(done_q, n);
    chk("abort latency", n, 115);
    chk("abort result", result_q, 8'hc3);
    $display("abort test ended");
    go();
    // Rate change mid-run must wait for the next start
    acr_rate_hi = 1'b1;
    wait_hi(done_q, n);
    wait_hi(autozero_q, m);
    chk("slow period", n + m, 200);
    go();
    wait_hi(done_q, n);
    wait_hi(autozero_q, m);
    chk("fast period", n + m, 150);
    $display("rate test ended");
    level = 8'h5a;
    go();
    repeat (40) @(negedge clk_sys);
    acr_enable = 1'b0;
    @(negedge clk_sys);
    chk("off busy", busy_q, 1'b0);
    go();
    act = 1'b0;
    repeat (300) @(negedge clk_sys)
      act |= busy_q | autozero_q | sample_q | done_q;
    chk("off activity", act, 1'b0);
    chk("off result", result_q, 8'hc3);
    acr_enable = 1'b1;
    go();
    wait_hi(done_q, n);
    chk("on result", result_q, 8'h5a);
    $display("disable test ended");
    end_sim();
  end
endmodule // acc_ctrl_bench
bind acc_ctrl acc_checker chk_u (.clk_sys(clk_sys), .rst(rst),
  .acr_start(acr_start), .acr_enable(acr_enable), .acr_rate_hi(acr_rate_hi),
  .flash_nibble(flash_nibble), .autozero_q(autozero_q), .sample_q(sample_q),
  .ladder_lsb_q(ladder_lsb_q), .busy_q(busy_q), .done_q(done_q),
  .result_q(result_q));

// ===== sim/acc_flash_model.sv
`timescale 1ns/100ps
module acc_flash_model
(
  input  wire logic       clk_sys,
  input  wire logic       sample_q,
  input  wire logic       ladder_lsb_q,
  input  wire logic [7:0] level,
  output logic      [3:0] flash_nibble
);
  logic [3:0] junk_q = 4'h0;
  // Switched out: moving pattern so a stale nibble looks right only one cycle in 16
  always @(posedge clk_sys) junk_q <= junk_q + 4'h7;
  assign flash_nibble = !sample_q ? junk_q :
                        ladder_lsb_q ? level[3:0] : level[7:4];
endmodule // acc_flash_model
